/* hdl/coincidence_delay_gate_unit.sv */
// Coincidence delay and gate pulse unit with delay line programming registers
// Overview of operation
// - Two-bit select picks programmable line 0, 1 or oscillator line 0, 1.
// - Update enable set loads chosen value continuously; cleared keeps line value.
// - Source select zero uses switches, one uses low 8 bits of value register.
// - Target select picks which programmable line is programmed and accessed.
// - After reset the switches program line 0; switch changes reach the line one clock later.
// - Written value register holds the delay applied when bus is the source.
// - Reading the value register returns the current switch setting.
// - Gate length register sets the width of the gate output in oscillator mode.
// - Rising edge of coincidence raises delay launch.
// - In line mode launch fires a 375 ns (15 clock) one-shot onto line input.
// - Line pulse out is line input ORed with line output.
// - Falling edge of line pulse out clears delay launch.
// - In oscillator mode launch enables chosen oscillator and the period counter.
// - Each oscillator tick rising edge after the first advances the period counter; the tick where it would reach gate length clears it.
// - First tick after coincidence raises gate; held for gate length periods.
// - Gate length is 16 bits, up to 65536 oscillator periods.
`default_nettype none

module coincidence_delay_gate_unit
   import coincidence_delay_gate_pkg::*;
#(
   parameter int PULSE_CYCLES = LAUNCH_PULSE_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Register access
   input  wire reg_req_t              reg_req,
   output logic [REG_DW-1:0]          reg_rdata,
   output logic                       reg_ack,
   // On-board switches
   input  wire logic [DELAY_W-1:0]    switch_line_0,
   input  wire logic [DELAY_W-1:0]    switch_line_1,
   // Programmable delay lines
   output logic [DELAY_W-1:0]         prog_bus_0,
   output logic [DELAY_W-1:0]         prog_bus_1,
   output logic                       line_input_0,
   output logic                       line_input_1,
   input  wire logic                  line_output_0,
   input  wire logic                  line_output_1,
   // Delay line oscillators
   output logic                       osc_enable_0,
   output logic                       osc_enable_1,
   input  wire logic                  osc_tick_0,
   input  wire logic                  osc_tick_1,
   // Pulse path
   input  wire logic                  coincidence_event,
   output logic                       delay_launch,
   output logic                       line_pulse_out,
   output logic                       gate_output,
   output logic [GATE_LEN_W-1:0]      period_count
);

   localparam logic [GATE_LEN_W-1:0] COUNT_ONE = 16'h0001;
   // Rising edge between a previous and a current sample
   function automatic logic rise(input logic prev, input logic cur);
      rise = cur & ~prev;
   endfunction
   // Switch setting of one programmable line
   function automatic logic [DELAY_W-1:0] pick_switch(input logic target,
                                                       input logic [DELAY_W-1:0] sw0,
                                                       input logic [DELAY_W-1:0] sw1);
      pick_switch = target ? sw1 : sw0;
   endfunction
   // Register state
   logic                   update_en_r;
   logic                   source_sel_r;
   logic                   target_sel_r;
   logic [REG_DW-1:0]      prog_value_r;
   line_sel_t              line_sel_r;
   logic [GATE_LEN_W-1:0]  gate_length_r;
   logic [REG_DW-1:0]      rdata_r;
   logic                   ack_r;
   // Line programming state
   logic [DELAY_W-1:0]     prog_line_0_r;
   logic [DELAY_W-1:0]     prog_line_1_r;
   logic [DELAY_W-1:0]     prog_pick;
   // Pulse sequencer state
   pulse_state_t           state_r;
   line_sel_t              active_line_r;
   logic                   launch_r;
   logic                   event_prev_r;
   logic                   tick_prev_r;
   logic                   pulse_r;
   logic                   gate_r;
   logic                   osc_en_0_r;
   logic                   osc_en_1_r;
   logic [GATE_LEN_W-1:0]  count_r;
   // Combinational helpers
   logic                   wr_ctrl;
   logic                   wr_value;
   logic                   wr_select;
   logic                   wr_gate;
   logic                   event_rise;
   logic                   shot_fire;
   logic                   shot_active;
   logic                   line_out_sel;
   logic                   pulse_comb;
   logic                   pulse_fall;
   logic                   tick_sel;
   logic                   tick_rise;
   logic [GATE_LEN_W-1:0]  count_inc;
   assign wr_ctrl   = reg_req.wr && (reg_req.addr == OFS_PROG_CTRL);
   assign wr_value  = reg_req.wr && (reg_req.addr == OFS_PROG_VALUE);
   assign wr_select = reg_req.wr && (reg_req.addr == OFS_LINE_SELECT);
   assign wr_gate   = reg_req.wr && (reg_req.addr == OFS_GATE_LENGTH);
   // Control register, reset lets switches program line 0 directly
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         update_en_r  <= PROG_CTRL_RST[CTRL_UPDATE_BIT];
         source_sel_r <= PROG_CTRL_RST[CTRL_SOURCE_BIT];
         target_sel_r <= PROG_CTRL_RST[CTRL_TARGET_BIT];
      end else if (wr_ctrl) begin
         update_en_r  <= reg_req.wdata[CTRL_UPDATE_BIT];
         source_sel_r <= reg_req.wdata[CTRL_SOURCE_BIT];
         target_sel_r <= reg_req.wdata[CTRL_TARGET_BIT];
      end
   end
   // Bus-written delay value
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prog_value_r <= PROG_VALUE_RST;
      end else if (wr_value) begin
         prog_value_r <= reg_req.wdata;
      end
   end
   // Delay source select and gate length
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         line_sel_r    <= SEL_PROG_0;
         gate_length_r <= GATE_LENGTH_RST;
      end else begin
         if (wr_select) begin
            line_sel_r <= line_sel_t'(reg_req.wdata[1:0]);
         end
         if (wr_gate) begin
            gate_length_r <= reg_req.wdata[GATE_LEN_W-1:0];
         end
      end
   end

   // Register read data and acknowledge, one cycle after the request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= '0;
         ack_r   <= 1'b0;
      end else begin
         ack_r <= reg_req.wr | reg_req.rd;
         if (reg_req.rd) begin
            case (reg_req.addr)
               OFS_PROG_CTRL: begin
                  rdata_r <= {13'h0000, target_sel_r, source_sel_r, update_en_r};
               end
               OFS_PROG_VALUE: begin
                  rdata_r <= {8'h00, pick_switch(target_sel_r,
                                                 switch_line_0, switch_line_1)};
               end
               OFS_LINE_SELECT: begin
                  rdata_r <= {14'h0000, line_sel_r};
               end
               OFS_GATE_LENGTH: begin
                  rdata_r <= gate_length_r;
               end
               default: begin
                  rdata_r <= '0;
               end
            endcase
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_ack   = ack_r;

   // Chosen programming value: switches or low byte of the bus value
   assign prog_pick = source_sel_r ? prog_value_r[DELAY_W-1:0]
                                   : pick_switch(target_sel_r, switch_line_0, switch_line_1);

   // Continuous load into the target line while updates are enabled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prog_line_0_r <= LINE_PROG_RST;
         prog_line_1_r <= LINE_PROG_RST;
      end else if (update_en_r) begin
         if (target_sel_r) begin
            prog_line_1_r <= prog_pick;
         end else begin
            prog_line_0_r <= prog_pick;
         end
      end
   end

   assign prog_bus_0 = prog_line_0_r;
   assign prog_bus_1 = prog_line_1_r;

   // Edge history of coincidence and selected oscillator tick
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         event_prev_r <= 1'b0;
         tick_prev_r  <= 1'b0;
      end else begin
         event_prev_r <= coincidence_event;
         tick_prev_r  <= tick_sel;
      end
   end

   assign event_rise   = rise(event_prev_r, coincidence_event);
   assign tick_sel     = (active_line_r == SEL_OSC_1) ? osc_tick_1 : osc_tick_0;
   assign tick_rise    = (state_r == ST_OSC_WAIT || state_r == ST_OSC_GATE) &&
                         rise(tick_prev_r, tick_sel);
   assign count_inc    = count_r + COUNT_ONE;
   assign shot_fire    = (state_r == ST_IDLE) && event_rise && !line_sel_r[1];

   // Launch pulse onto the programmable line
   launch_one_shot #(
      .CYCLES  (PULSE_CYCLES)
   ) u_one_shot (
      .clk     (clk),
      .rst_n   (rst_n),
      .trigger (shot_fire),
      .active  (shot_active)
   );

   assign line_out_sel = (active_line_r == SEL_PROG_1) ? line_output_1 : line_output_0;
   assign pulse_comb   = (state_r == ST_LINE_RUN) && (shot_active | line_out_sel);
   assign pulse_fall   = pulse_r & ~pulse_comb;

   // Pulse sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r       <= ST_IDLE;
         active_line_r <= SEL_PROG_0;
         launch_r      <= 1'b0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (event_rise) begin
                  launch_r      <= 1'b1;
                  active_line_r <= line_sel_r;
                  state_r       <= line_sel_r[1] ? ST_OSC_WAIT : ST_LINE_RUN;
               end
            end
            ST_LINE_RUN: begin
               if (pulse_fall) begin
                  launch_r <= 1'b0;
                  state_r  <= ST_IDLE;
               end
            end
            ST_OSC_WAIT: begin
               if (tick_rise) begin
                  state_r <= ST_OSC_GATE;
               end
            end
            ST_OSC_GATE: begin
               if (tick_rise && count_inc == gate_length_r) begin
                  launch_r <= 1'b0;
                  state_r  <= ST_IDLE;
               end
            end
            default: begin
               launch_r <= 1'b0;
               state_r  <= ST_IDLE;
            end
         endcase
      end
   end

   // Oscillator enables follow the launch in oscillator mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         osc_en_0_r <= 1'b0;
         osc_en_1_r <= 1'b0;
      end else if (state_r == ST_IDLE && event_rise && line_sel_r[1]) begin
         osc_en_0_r <= (line_sel_r == SEL_OSC_0);
         osc_en_1_r <= (line_sel_r == SEL_OSC_1);
      end else if (state_r == ST_OSC_GATE && tick_rise && count_inc == gate_length_r) begin
         osc_en_0_r <= 1'b0;
         osc_en_1_r <= 1'b0;
      end
   end

   // Period counter, gate length zero wraps to 65536 periods
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (state_r == ST_OSC_GATE && tick_rise) begin
         if (count_inc == gate_length_r) begin
            count_r <= '0;
         end else begin
            count_r <= count_inc;
         end
      end else if (state_r == ST_IDLE) begin
         count_r <= '0;
      end
   end

   // Gate output: line pulse in line mode, counted gate in oscillator mode
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_r <= 1'b0;
         gate_r  <= 1'b0;
      end else begin
         pulse_r <= pulse_comb;
         case (state_r)
            ST_LINE_RUN: begin
               gate_r <= pulse_comb;
            end
            ST_OSC_WAIT: begin
               gate_r <= tick_rise;
            end
            ST_OSC_GATE: begin
               gate_r <= !(tick_rise && count_inc == gate_length_r);
            end
            default: begin
               gate_r <= 1'b0;
            end
         endcase
      end
   end

   // Route the one-shot to the line captured at launch
   assign line_input_0   = shot_active && (active_line_r == SEL_PROG_0);
   assign line_input_1   = shot_active && (active_line_r == SEL_PROG_1);
   assign osc_enable_0   = osc_en_0_r;
   assign osc_enable_1   = osc_en_1_r;
   assign delay_launch   = launch_r;
   assign line_pulse_out = pulse_r;
   assign gate_output    = gate_r;
   assign period_count   = count_r;

endmodule

`default_nettype wire

/* hdl/coincidence_delay_gate_pkg.sv */
// Constants, types and register map for the coincidence delay and gate unit
`default_nettype none

package coincidence_delay_gate_pkg;

   // Clock and launch pulse timing
   localparam int CLK_PERIOD_NS     = 25;
   localparam int LAUNCH_PULSE_NS   = 360;
   localparam int LINE_MIN_PULSE_NS = 320;
   localparam int LAUNCH_PULSE_CYC  = (LAUNCH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LINE_MIN_PULSE_CYC =
      (LINE_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Widths
   localparam int REG_AW      = 16;
   localparam int REG_DW      = 16;
   localparam int DELAY_W     = 8;
   localparam int GATE_LEN_W  = 16;

   // Register offsets
   localparam logic [REG_AW-1:0] OFS_PROG_CTRL   = 16'h103E;
   localparam logic [REG_AW-1:0] OFS_PROG_VALUE  = 16'h1040;
   localparam logic [REG_AW-1:0] OFS_LINE_SELECT = 16'h1048;
   localparam logic [REG_AW-1:0] OFS_GATE_LENGTH = 16'h104A;

   // Field positions in delay_program_control
   localparam int CTRL_UPDATE_BIT = 0;
   localparam int CTRL_SOURCE_BIT = 1;
   localparam int CTRL_TARGET_BIT = 2;
   localparam int CTRL_USED_W     = 3;

   // Values after reset
   localparam logic [CTRL_USED_W-1:0] PROG_CTRL_RST   = 3'h1;
   localparam logic [REG_DW-1:0]      PROG_VALUE_RST  = 16'h0000;
   localparam logic [GATE_LEN_W-1:0]  GATE_LENGTH_RST = 16'h0010;
   localparam logic [DELAY_W-1:0]     LINE_PROG_RST   = 8'h00;

   // Delay source selection
   typedef enum logic [1:0] {
      SEL_PROG_0 = 2'b00,
      SEL_PROG_1 = 2'b01,
      SEL_OSC_0  = 2'b10,
      SEL_OSC_1  = 2'b11
   } line_sel_t;

   // Pulse sequencer states, Gray coded along the path except idle to oscillator wait
   typedef enum logic [1:0] {
      ST_IDLE     = 2'b00,
      ST_LINE_RUN = 2'b01,
      ST_OSC_WAIT = 2'b11,
      ST_OSC_GATE = 2'b10
   } pulse_state_t;

   // Register bus request
   typedef struct packed {
      logic [REG_AW-1:0] addr;
      logic [REG_DW-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

endpackage

`default_nettype wire

/* hdl/launch_one_shot.sv */
// Fixed-length one-shot pulse generator
`default_nettype none

module launch_one_shot
   import coincidence_delay_gate_pkg::*;
#(
   parameter int CYCLES = LAUNCH_PULSE_CYC
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic trigger,
   output logic      active
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES);
   localparam logic [CW-1:0] ONE  = CW'(1);

   logic [CW-1:0] remain_r;

   // Count down the pulse length
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         remain_r <= '0;
      end else if (trigger) begin
         remain_r <= LOAD;
      end else if (remain_r != '0) begin
         remain_r <= remain_r - ONE;
      end
   end

   assign active = (remain_r != '0);

endmodule

`default_nettype wire

/* tb/coincidence_delay_gate_monitor.sv */
// Port checker for the coincidence delay and gate unit
`default_nettype none
module coincidence_delay_gate_monitor
   import coincidence_delay_gate_pkg::*;
#(
   parameter int PULSE_CYCLES = LAUNCH_PULSE_CYC
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  reg_ack,
   input wire logic [DELAY_W-1:0]    switch_line_0,
   input wire logic [DELAY_W-1:0]    switch_line_1,
   input wire logic [DELAY_W-1:0]    prog_bus_0,
   input wire logic [DELAY_W-1:0]    prog_bus_1,
   input wire logic                  line_input_0,
   input wire logic                  line_input_1,
   input wire logic                  line_output_0,
   input wire logic                  line_output_1,
   input wire logic                  osc_enable_0,
   input wire logic                  osc_enable_1,
   input wire logic                  osc_tick_0,
   input wire logic                  osc_tick_1,
   input wire logic                  coincidence_event,
   input wire logic                  delay_launch,
   input wire logic                  line_pulse_out,
   input wire logic                  gate_output,
   input wire logic [GATE_LEN_W-1:0] period_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic       shot;
   logic [7:0] shot_cnt_r;
   assign shot = line_input_0 | line_input_1;
   // Length of the current launch pulse
   always_ff @(posedge clk) begin
      if (!rst_n || !shot) shot_cnt_r <= 8'h00;
      else shot_cnt_r <= shot_cnt_r + 8'h01;
   end
   sequence s_event_rise;
      $rose(coincidence_event) && !delay_launch;
   endsequence
   sequence s_pulse_end;
      $fell(gate_output);
   endsequence
   a_launch_on_event: assert property (s_event_rise |=> delay_launch)
      else $error("launch missing after coincidence");
   a_shot_width: assert property ($fell(shot) |-> shot_cnt_r == 8'(PULSE_CYCLES))
      else $error("launch pulse width wrong");
   a_pulse_or: assert property (line_pulse_out ==
      $past(line_input_0 || line_output_0 || line_input_1 || line_output_1))
      else $error("line pulse is not input or output");
   a_launch_clear: assert property ($fell(line_pulse_out) |-> !delay_launch)
      else $error("launch not cleared at pulse end");
   a_launch_enables: assert property ($rose(delay_launch) |->
      (line_input_0 || line_input_1 || osc_enable_0 || osc_enable_1))
      else $error("launch enabled nothing");
   a_count_steps: assert property ($changed(period_count) |->
      period_count == 16'($past(period_count) + 16'h0001) || period_count == 16'h0000)
      else $error("period counter jumped");
   a_gate_on_tick: assert property ($rose(gate_output) |->
      line_pulse_out || $past(osc_tick_0 || osc_tick_1))
      else $error("gate rose without tick");
   a_gate_stop_all: assert property (s_pulse_end |-> !delay_launch &&
      !osc_enable_0 && !osc_enable_1 && period_count == 16'h0000)
      else $error("pulse end left state behind");
   a_bus_hold_0: assert property ($changed(prog_bus_0) |->
      prog_bus_0 == $past(switch_line_0) || $past(reg_ack))
      else $error("line 0 bus changed without cause");
   a_bus_hold_1: assert property ($changed(prog_bus_1) |->
      prog_bus_1 == $past(switch_line_1) || $past(reg_ack))
      else $error("line 1 bus changed without cause");
endmodule
bind coincidence_delay_gate_unit coincidence_delay_gate_monitor #(
   .PULSE_CYCLES(PULSE_CYCLES)
) i_coincidence_delay_gate_monitor (.*);
`default_nettype wire

/* tb/delay_line_partner.sv */
// Behavioural programmable delay lines and delay line oscillators
`default_nettype none
module delay_line_partner
   import coincidence_delay_gate_pkg::*;
#(
   parameter int TICK_HALF = 2
) (
   input  wire logic               clk,
   input  wire logic [DELAY_W-1:0] prog_bus_0,
   input  wire logic [DELAY_W-1:0] prog_bus_1,
   input  wire logic               line_input_0,
   input  wire logic               line_input_1,
   input  wire logic               osc_enable_0,
   input  wire logic               osc_enable_1,
   output logic                    line_output_0,
   output logic                    line_output_1,
   output logic                    osc_tick_0,
   output logic                    osc_tick_1
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [63:0] hist_0_r = '0;
   logic [63:0] hist_1_r = '0;
   int          phase_0_r = 0;
   int          phase_1_r = 0;
   always_ff @(posedge clk) begin
      hist_0_r <= {hist_0_r[62:0], line_input_0};
      hist_1_r <= {hist_1_r[62:0], line_input_1};
      phase_0_r <= osc_enable_0 ? (phase_0_r + 1) % (2 * TICK_HALF) : 0;
      phase_1_r <= osc_enable_1 ? (phase_1_r + 1) % (2 * TICK_HALF) : 0;
   end
   // Output repeats the input a bus value of clock cycles later
   assign line_output_0 = (prog_bus_0 == 8'h00) ? line_input_0 :
                          hist_0_r[prog_bus_0[5:0] - 6'h01];
   assign line_output_1 = (prog_bus_1 == 8'h00) ? line_input_1 :
                          hist_1_r[prog_bus_1[5:0] - 6'h01];
   // Oscillators stay low while disabled
   assign osc_tick_0 = osc_enable_0 && (phase_0_r >= TICK_HALF);
   assign osc_tick_1 = osc_enable_1 && (phase_1_r >= TICK_HALF);
endmodule
`default_nettype wire

/* tb/coincidence_delay_gate_unit_tb.sv */
// Self-checking testbench for the coincidence delay and gate unit
`default_nettype none
module coincidence_delay_gate_unit_tb
   import coincidence_delay_gate_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PC  = LAUNCH_PULSE_CYC;
   localparam int TH  = 2;
   localparam int PER = 2 * TH;
   logic        clk;
   logic        rst_n;
   reg_req_t    req;
   logic [15:0] rdata;
   logic        ack;
   logic [7:0]  sw0;
   logic [7:0]  sw1;
   logic [7:0]  pb0;
   logic [7:0]  pb1;
   logic        li0;
   logic        li1;
   logic        lo0;
   logic        lo1;
   logic        oe0;
   logic        oe1;
   logic        tk0;
   logic        tk1;
   logic        cev;
   logic        launch;
   logic        lpo;
   logic        gate;
   logic [15:0] pcount;
   int          fail_count;
   int          tests_run;
   coincidence_delay_gate_unit #(.PULSE_CYCLES(PC)) i_coincidence_delay_gate_unit (
      .clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .reg_ack(ack),
      .switch_line_0(sw0), .switch_line_1(sw1), .prog_bus_0(pb0), .prog_bus_1(pb1),
      .line_input_0(li0), .line_input_1(li1), .line_output_0(lo0), .line_output_1(lo1),
      .osc_enable_0(oe0), .osc_enable_1(oe1), .osc_tick_0(tk0), .osc_tick_1(tk1),
      .coincidence_event(cev), .delay_launch(launch), .line_pulse_out(lpo),
      .gate_output(gate), .period_count(pcount));
   delay_line_partner #(.TICK_HALF(TH)) i_delay_line_partner (
      .clk(clk), .prog_bus_0(pb0), .prog_bus_1(pb1), .line_input_0(li0),
      .line_input_1(li1), .osc_enable_0(oe0), .osc_enable_1(oe1),
      .line_output_0(lo0), .line_output_1(lo1), .osc_tick_0(tk0), .osc_tick_1(tk1));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // One register access, strobe held for a single cycle
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      req <= '0;
      #1;
      chk("reg_ack", 16'h0001, {15'h0000, ack});
      q = rdata;
   endtask
   // Coincidence, then width of line pulse (m=0) or gate (m=1)
   task automatic fire(input logic m, output int w, output logic [3:0] act);
      int t;
      w = 0;
      t = 0;
      act = 4'h0;
      @(posedge clk);
      cev <= 1'b1;
      while ((m ? gate : lpo) !== 1'b1 && t < 200) begin
         wait_cyc(1);
         act |= {oe1, oe0, li1, li0};
         t++;
      end
      while ((m ? gate : lpo) === 1'b1 && w < 400) begin
         wait_cyc(1);
         w++;
      end
      @(posedge clk);
      cev <= 1'b0;
      wait_cyc(2);
   endtask
   task automatic t_reset;
      logic [15:0] q;
      acc(1'b0, OFS_PROG_CTRL, 16'h0000, q);
      chk("control", 16'h0001, q);
      acc(1'b0, OFS_GATE_LENGTH, 16'h0000, q);
      chk("gate_length", 16'h0010, q);
      acc(1'b0, 16'h1050, 16'h0000, q);
      chk("unmapped", 16'h0000, q);
      chk("prog_bus_0", 16'h0013, {8'h00, pb0});
      @(posedge clk);
      sw0 <= 8'h2C;
      wait_cyc(2);
      chk("prog_bus_0", 16'h002C, {8'h00, pb0});
      acc(1'b0, OFS_PROG_VALUE, 16'h0000, q);
      chk("value read", 16'h002C, q);
      $display("t_reset done");
   endtask
   task automatic t_line;
      logic [15:0] q;
      logic [3:0]  a;
      int          w;
      acc(1'b1, OFS_PROG_CTRL, 16'h0003, q);
      acc(1'b1, OFS_PROG_VALUE, 16'h1A04, q);
      wait_cyc(1);
      chk("prog_bus_0", 16'h0004, {8'h00, pb0});
      acc(1'b0, OFS_PROG_VALUE, 16'h0000, q);
      chk("value read", 16'h002C, q);
      acc(1'b1, OFS_LINE_SELECT, 16'h0000, q);
      fire(1'b0, w, a);
      chk("line 0 width", 16'(PC + 4), 16'(w));
      chk("line 0 used", 16'h0001, {12'h000, a});
      chk("launch", 16'h0000, {15'h0000, launch});
      acc(1'b1, OFS_PROG_CTRL, 16'h0007, q);
      acc(1'b1, OFS_PROG_VALUE, 16'h0009, q);
      wait_cyc(1);
      chk("prog_bus_1", 16'h0009, {8'h00, pb1});
      chk("prog_bus_0", 16'h0004, {8'h00, pb0});
      acc(1'b1, OFS_PROG_CTRL, 16'h0006, q);
      acc(1'b1, OFS_PROG_VALUE, 16'h0011, q);
      wait_cyc(2);
      chk("frozen bus", 16'h0009, {8'h00, pb1});
      acc(1'b1, OFS_LINE_SELECT, 16'h0001, q);
      fire(1'b0, w, a);
      chk("line 1 width", 16'(PC + 9), 16'(w));
      chk("line 1 used", 16'h0002, {12'h000, a});
      acc(1'b1, OFS_PROG_CTRL, 16'h0005, q);
      @(posedge clk);
      sw1 <= 8'h07;
      wait_cyc(2);
      chk("prog_bus_1", 16'h0007, {8'h00, pb1});
      acc(1'b0, OFS_PROG_VALUE, 16'h0000, q);
      chk("value read", 16'h0007, q);
      $display("t_line done");
   endtask
   task automatic t_osc;
      logic [15:0] q;
      logic [3:0]  a;
      int          w;
      acc(1'b1, OFS_GATE_LENGTH, 16'hFFFF, q);
      acc(1'b0, OFS_GATE_LENGTH, 16'h0000, q);
      chk("gate_length", 16'hFFFF, q);
      for (int i = 0; i < 2; i++) begin
         acc(1'b1, OFS_GATE_LENGTH, 16'(3 + 2 * i), q);
         acc(1'b1, OFS_LINE_SELECT, 16'(2 + i), q);
         acc(1'b0, OFS_LINE_SELECT, 16'h0000, q);
         chk("line select", 16'(2 + i), q);
         fire(1'b1, w, a);
         chk("gate width", 16'((3 + 2 * i) * PER), 16'(w));
         chk("osc used", 16'(4 << i), {12'h000, a});
         chk("period_count", 16'h0000, pcount);
         chk("idle", 16'h0000, {13'h0000, launch, oe1, oe0});
      end
      $display("t_osc done");
   endtask
   initial begin
      rst_n = 1'b0;
      req = '0;
      sw0 = 8'h13;
      sw1 = 8'h00;
      cev = 1'b0;
      fail_count = 0;
      tests_run = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_line;
      t_osc;
      give_verdict;
   end
   initial begin
      #2000000;
      fail_count++;
      give_verdict;
   end
endmodule
`default_nettype wire
